// [rtl/iox_pkg.sv]
// Shared constants and types of the sixteen-bit serial I/O expander
package iox_pkg;

  // ----------------------------------------------------------------
  // Register pointer codes
  // ----------------------------------------------------------------
  localparam logic [2:0] REG_IN_LO = 3'h0;
  localparam logic [2:0] REG_IN_HI = 3'h1;
  localparam logic [2:0] REG_OUT_LO = 3'h2;
  localparam logic [2:0] REG_OUT_HI = 3'h3;
  localparam logic [2:0] REG_POL_LO = 3'h4;
  localparam logic [2:0] REG_POL_HI = 3'h5;
  localparam logic [2:0] REG_CFG_LO = 3'h6;
  localparam logic [2:0] REG_CFG_HI = 3'h7;
  localparam int REG_COUNT = 8;

  // ----------------------------------------------------------------
  // Reset values and layout
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_IN = 8'h00;
  localparam logic [7:0] RST_OUT = 8'hFF;
  localparam logic [7:0] RST_POL = 8'h00;
  localparam logic [7:0] RST_CFG = 8'hFF;
  localparam int PORT_BITS = 8;
  localparam int PORT_LO_BIT_FIRST = 0;
  localparam int PORT_HI_BIT_FIRST = 8;

  // ----------------------------------------------------------------
  // Serial protocol constants
  // ----------------------------------------------------------------
  localparam logic [3:0] DEV_ADDR_BASE = 4'h4;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [1:0] PRIME_CYCLES = 2'h3;

  // Protocol states, Gray coded along the write path
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_AACK = 4'h3,
    ST_CMD = 4'h2,
    ST_CACK = 4'h6,
    ST_WR = 4'h7,
    ST_WACK = 4'h5,
    ST_RD = 4'h4,
    ST_RACK = 4'hC
  } iox_state_e;

  // Reset value of a register entry
  function automatic logic [7:0] iox_rst_value(input logic [2:0] idx);
    logic [7:0] val;
    val = RST_IN;
    if (idx == REG_OUT_LO || idx == REG_OUT_HI) val = RST_OUT;
    if (idx == REG_POL_LO || idx == REG_POL_HI) val = RST_POL;
    if (idx == REG_CFG_LO || idx == REG_CFG_HI) val = RST_CFG;
    return val;
  endfunction : iox_rst_value

endpackage : iox_pkg

// [rtl/iox_reg_if.sv]
// Register bank link between protocol core and register storage
`timescale 1ns/1ps
interface iox_reg_if;
  logic wrEn;
  logic [2:0] wrAddr;
  logic [7:0] wrData;
  logic [2:0] rdAddr;
  logic [7:0] rdData;
  logic [7:0] outLo;
  logic [7:0] outHi;
  logic [7:0] polLo;
  logic [7:0] polHi;
  logic [7:0] cfgLo;
  logic [7:0] cfgHi;

  modport bank (
    input wrEn, wrAddr, wrData, rdAddr,
    output rdData, outLo, outHi, polLo, polHi, cfgLo, cfgHi
  );
  modport core (
    output wrEn, wrAddr, wrData, rdAddr,
    input rdData, outLo, outHi, polLo, polHi, cfgLo, cfgHi
  );
endinterface : iox_reg_if

// [rtl/iox_regfile.sv]
// Output, polarity and direction register storage with registered read
`timescale 1ns/1ps
module iox_regfile
  import iox_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  iox_reg_if.bank bus
);

  logic [8*REG_COUNT-1:0] flat;
  logic [7:0] rdData;
  logic [7:0] next_rdData;

  // ----------------------------------------------------------------
  // Register entries
  // ----------------------------------------------------------------
  for (genvar i = 0; i < REG_COUNT; i++) begin : gEntry
    localparam logic [2:0] IDX = 3'(i);
    logic [7:0] val;
    logic [7:0] next_val;
    always_comb begin
      next_val = val;
      if (bus.wrEn && bus.wrAddr == IDX && IDX >= REG_OUT_LO) next_val = bus.wrData;
    end
    always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) val <= iox_rst_value(IDX);
      else val <= next_val;
    end
    assign flat[i*8 +: 8] = val;
  end

  // Registered read data
  always_comb begin
    next_rdData = flat[{bus.rdAddr, 3'h0} +: 8];
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) rdData <= RST_IN;
    else rdData <= next_rdData;
  end

  // Register fields towards the core
  assign bus.rdData = rdData;
  assign bus.outLo = flat[REG_OUT_LO*8 +: 8];
  assign bus.outHi = flat[REG_OUT_HI*8 +: 8];
  assign bus.polLo = flat[REG_POL_LO*8 +: 8];
  assign bus.polHi = flat[REG_POL_HI*8 +: 8];
  assign bus.cfgLo = flat[REG_CFG_LO*8 +: 8];
  assign bus.cfgHi = flat[REG_CFG_HI*8 +: 8];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_write_stores_byte: assert property (@(posedge clk_sys) disable iff (!nrst)
    (bus.wrEn && bus.wrAddr >= REG_OUT_LO) |=> flat[{$past(bus.wrAddr), 3'h0} +: 8] == $past(bus.wrData))
    else $error("written byte not stored");
  a_input_read_only: assert property (@(posedge clk_sys) disable iff (!nrst)
    flat[15:0] == 16'h0000)
    else $error("input entries changed by a write");

endmodule : iox_regfile

// [rtl/iox_expander.sv]
// Sixteen-bit serial-bus I/O expander: protocol target, ports and interrupt
// Operation
// - Sixteen lines in two byte ports, each line controlled from the serial bus.
// - Each port has input, output, direction and polarity byte registers.
// - After reset every line is an undriven input.
// - Each line's direction comes from its own direction register bit.
// - Interrupt asserts while any line differs from its last captured input bit.
// - Interrupt pin is open drain, pulled low while asserted.
// - Reset loads register defaults and returns protocol logic to idle.
// - Target address holds the three strap levels; eight devices share a bus.
// - Output lines hold the last written output value until rewritten or reset.
// - Port pins 0 to 7 map to register bits 0 to 7 of their port.
// - Output lines drive both high and low per the output register bit.
// - Address byte bit zero: one means controller reads, zero means writes.
// - Command byte low three bits select one of eight registers into pointer.
// - Direction bit one makes an input, zero makes an output.
`timescale 1ns/1ps
module iox_expander
  import iox_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic addrStrap0,
  input wire logic addrStrap1,
  input wire logic addrStrap2,
  input wire logic [7:0] portLoIn,
  output logic [7:0] portLoOut,
  output logic [7:0] portLoOe,
  input wire logic [7:0] portHiIn,
  output logic [7:0] portHiOut,
  output logic [7:0] portHiOe,
  output logic intOut,
  output logic intOe
);

  iox_reg_if bus ();
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic sclMeta, sclSync, sclPrev, sdaMeta, sdaSync, sdaPrev;
  logic [15:0] pinMeta, pinSync;
  logic [2:0] strapMeta, strapSync;
  // Two flops on every outside input but nrst, plus edge history on clock and data
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      {sclMeta, sclSync, sclPrev, sdaMeta, sdaSync, sdaPrev} <= 6'h3F;
      {pinMeta, pinSync, strapMeta, strapSync} <= 38'h0;
    end else begin
      {sclPrev, sclSync, sclMeta} <= {sclSync, sclMeta, sclIn};
      {sdaPrev, sdaSync, sdaMeta} <= {sdaSync, sdaMeta, sdaIn};
      {pinSync, pinMeta} <= {pinMeta, portHiIn, portLoIn};
      {strapSync, strapMeta} <= {strapMeta, addrStrap2, addrStrap1, addrStrap0};
    end
  end

  // Bus events
  logic sclRise, sclFall, startCond, stopCond, addrMatch;
  assign sclRise = sclSync & ~sclPrev;
  assign sclFall = ~sclSync & sclPrev;
  assign startCond = sclSync & sclPrev & sdaPrev & ~sdaSync;
  assign stopCond = sclSync & sclPrev & ~sdaPrev & sdaSync;
  // ----------------------------------------------------------------
  // Protocol state
  // ----------------------------------------------------------------
  iox_state_e state, next_state;
  logic [3:0] bitCnt, next_bitCnt;
  logic [7:0] shifter, next_shifter;
  logic [2:0] ptr, next_ptr;
  logic rwBit, next_rwBit;
  logic next_sdaOe;
  logic wrEn, next_wrEn;
  logic [15:0] snap, next_snap;
  logic [1:0] primeCnt, next_primeCnt;
  logic [7:0] inLo, inHi, readByte;
  logic loadByte;
  // pin index equals register bit index
  assign inLo = pinSync[PORT_LO_BIT_FIRST +: PORT_BITS] ^ bus.polLo;
  assign inHi = pinSync[PORT_HI_BIT_FIRST +: PORT_BITS] ^ bus.polHi;
  assign readByte = (ptr == REG_IN_LO) ? inLo : (ptr == REG_IN_HI) ? inHi : bus.rdData;
  assign addrMatch = shifter[7:1] == {DEV_ADDR_BASE, strapSync};
  assign loadByte = sclFall && ((state == ST_AACK && rwBit) || state == ST_RACK);
  // Next protocol values
  always_comb begin
    next_state = state;
    next_bitCnt = bitCnt;
    next_shifter = shifter;
    next_ptr = ptr;
    next_rwBit = rwBit;
    next_sdaOe = sdaOe;
    next_wrEn = 1'b0;
    next_snap = snap;
    next_primeCnt = primeCnt;
    // Capture pin levels once synchronisers settle after reset
    if (primeCnt != PRIME_CYCLES) begin
      next_primeCnt = primeCnt + 2'h1;
      next_snap = pinSync;
    end
    if (startCond) begin
      next_state = ST_ADDR;
      next_bitCnt = 4'h0;
      next_sdaOe = 1'b0;
    end else if (stopCond) begin
      next_state = ST_IDLE;
      next_sdaOe = 1'b0;
    end else begin
      case (state)
        ST_ADDR, ST_CMD, ST_WR: begin
          if (sclRise && bitCnt != BYTE_BITS) begin
            next_shifter = {shifter[6:0], sdaSync};
            next_bitCnt = bitCnt + 4'h1;
          end
          if (sclFall && bitCnt == BYTE_BITS) begin
            next_sdaOe = 1'b1;
            if (state == ST_ADDR) begin
              if (addrMatch) begin
                next_state = ST_AACK;
                next_rwBit = shifter[0];
              end else begin
                next_state = ST_IDLE;
                next_sdaOe = 1'b0;
              end
            end else if (state == ST_CMD) begin
              next_ptr = shifter[2:0];
              next_state = ST_CACK;
            end else begin
              next_wrEn = 1'b1;
              next_state = ST_WACK;
            end
          end
        end
        ST_AACK: begin
          if (sclFall) begin
            next_bitCnt = 4'h0;
            next_sdaOe = 1'b0;
            next_state = rwBit ? ST_RD : ST_CMD;
          end
        end
        ST_CACK, ST_WACK: begin
          if (sclFall) begin
            next_bitCnt = 4'h0;
            next_sdaOe = 1'b0;
            next_state = ST_WR;
            if (state == ST_WACK) next_ptr = ptr ^ 3'h1;
          end
        end
        ST_RD: begin
          if (sclRise) next_bitCnt = bitCnt + 4'h1;
          if (sclFall) begin
            if (bitCnt == BYTE_BITS) begin
              next_sdaOe = 1'b0;
              next_state = ST_RACK;
              next_ptr = ptr ^ 3'h1;
            end else begin
              next_shifter = {shifter[6:0], 1'b0};
              next_sdaOe = ~shifter[6];
            end
          end
        end
        ST_RACK: begin
          if (sclRise && sdaSync) next_state = ST_IDLE;
          if (sclFall) begin
            next_bitCnt = 4'h0;
            next_state = ST_RD;
          end
        end
        default: begin
          next_sdaOe = 1'b0;
        end
      endcase
      if (loadByte) begin
        next_shifter = readByte;
        next_sdaOe = ~readByte[7];
        if (ptr == REG_IN_LO) next_snap[7:0] = pinSync[7:0];
        if (ptr == REG_IN_HI) next_snap[15:8] = pinSync[15:8];
      end
    end
  end
  // idle state and defaults on reset
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state <= ST_IDLE;
      ptr <= REG_IN_LO;
      {bitCnt, shifter} <= 12'h000;
      {rwBit, sdaOe, wrEn} <= 3'h0;
      {snap, primeCnt} <= 18'h0;
    end else begin
      state <= next_state;
      ptr <= next_ptr;
      {bitCnt, shifter} <= {next_bitCnt, next_shifter};
      {rwBit, sdaOe, wrEn} <= {next_rwBit, next_sdaOe, next_wrEn};
      {snap, primeCnt} <= {next_snap, next_primeCnt};
    end
  end
  // Register bank connection
  assign bus.wrEn = wrEn;
  assign bus.wrAddr = ptr;
  assign bus.wrData = shifter;
  assign bus.rdAddr = ptr;
  iox_regfile uBank (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .bus(bus.bank)
  );

  // ----------------------------------------------------------------
  // Pin drivers and interrupt
  // ----------------------------------------------------------------
  logic [15:0] next_pinOut, next_pinOe;
  logic next_intOe;
  always_comb begin
    next_pinOut = {bus.outHi, bus.outLo};
    next_pinOe = ~{bus.cfgHi, bus.cfgLo};
    next_intOe = (primeCnt == PRIME_CYCLES) && (pinSync != snap);
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      {portHiOut, portLoOut} <= {RST_OUT, RST_OUT};
      {portHiOe, portLoOe} <= 16'h0000;
      {intOe, intOut, sdaOut} <= 3'h0;
    end else begin
      {portHiOut, portLoOut} <= next_pinOut;
      {portHiOe, portLoOe} <= next_pinOe;
      {intOe, intOut, sdaOut} <= {next_intOe, 2'h0};
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence sWrByteEnd;
    state == ST_WR && sclFall && bitCnt == BYTE_BITS && !startCond && !stopCond;
  endsequence
  sequence sStrobeOnce;
    wrEn && sdaOe ##1 !wrEn;
  endsequence
  a_dir_per_bit: assert property (@(posedge clk_sys) disable iff (!nrst)
    ##1 {portHiOe, portLoOe} == ~$past({bus.cfgHi, bus.cfgLo}))
    else $error("pin enable does not follow direction bits");
  a_out_levels: assert property (@(posedge clk_sys) disable iff (!nrst)
    ##1 portLoOut == $past(bus.outLo) && portHiOut == $past(bus.outHi))
    else $error("pin data does not follow output register");
  a_reset_inputs: assert property (@(posedge clk_sys) disable iff (!nrst)
    primeCnt != PRIME_CYCLES |-> {portHiOe, portLoOe} == 16'h0000 && !intOe)
    else $error("pin driven right after reset");
  a_int_on_diff: assert property (@(posedge clk_sys) disable iff (!nrst)
    (primeCnt == PRIME_CYCLES && pinSync != snap) |=> intOe)
    else $error("interrupt missing on input change");
  a_int_release: assert property (@(posedge clk_sys) disable iff (!nrst)
    (pinSync == snap) |=> !intOe)
    else $error("interrupt held with no mismatch");
  a_int_drain: assert property (@(posedge clk_sys) disable iff (!nrst)
    intOut == 1'b0 && sdaOut == 1'b0)
    else $error("open drain pin drives high");
  a_addr_ack: assert property (@(posedge clk_sys) disable iff (!nrst)
    (state == ST_ADDR && sclFall && bitCnt == BYTE_BITS && !startCond && !stopCond)
    |=> (state == ($past(addrMatch) ? ST_AACK : ST_IDLE)) && (sdaOe == $past(addrMatch)))
    else $error("address answer wrong");
  a_dir_branch: assert property (@(posedge clk_sys) disable iff (!nrst)
    (state == ST_AACK && sclFall && !startCond && !stopCond)
    |=> state == ($past(rwBit) ? ST_RD : ST_CMD))
    else $error("wrong transfer direction");
  a_cmd_pointer: assert property (@(posedge clk_sys) disable iff (!nrst)
    (state == ST_CMD && sclFall && bitCnt == BYTE_BITS && !startCond && !stopCond)
    |=> ptr == $past(shifter[2:0]) && state == ST_CACK)
    else $error("pointer not loaded from command");
  a_write_strobe: assert property (@(posedge clk_sys) disable iff (!nrst)
    sWrByteEnd |=> sStrobeOnce)
    else $error("write strobe not a single pulse with ack");
  a_polarity_read: assert property (@(posedge clk_sys) disable iff (!nrst)
    (loadByte && ptr == REG_IN_LO && !startCond && !stopCond)
    |=> shifter == $past(inLo) && snap[7:0] == $past(pinSync[7:0]))
    else $error("input read value or capture wrong");

endmodule : iox_expander

// [testbench/iox_bus_ctrl.sv]
// Serial bus controller model: link clock, open-drain data and byte transfers
`timescale 1ns/1ps
module iox_bus_ctrl (
  input wire logic clk_sys,
  input wire logic sdaLine,
  output logic sclLine,
  output logic sdaDrv
);
  // ------------------------------------------------------------
  // Bus timing
  // ------------------------------------------------------------
  localparam int HALF = 10; // Clocks per half of the 160 ns link clock

  // Both lines released at start, clock stands still high between frames
  initial begin
    sclLine = 1'b1;
    sdaDrv = 1'b1;
  end

  // Wait a number of system clocks
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick

  // Start or repeated start: data falls while clock is high
  task automatic start_cond();
    sdaDrv <= 1'b1;
    tick(HALF / 2);
    sclLine <= 1'b1;
    tick(HALF);
    sdaDrv <= 1'b0;
    tick(HALF);
    sclLine <= 1'b0;
  endtask : start_cond

  // Stop: data rises while clock is high, then lines stay released
  task automatic stop_cond();
    tick(3);
    sdaDrv <= 1'b0;
    tick(HALF);
    sclLine <= 1'b1;
    tick(HALF);
    sdaDrv <= 1'b1;
    tick(HALF);
  endtask : stop_cond

  // One bit: data set in the low phase, wire sampled mid high phase
  task automatic bit_xfer(input logic txBit, output logic rxBit);
    tick(3);
    sdaDrv <= txBit;
    tick(HALF - 3);
    sclLine <= 1'b1;
    tick(HALF / 2);
    rxBit = sdaLine;
    tick(HALF - HALF / 2);
    sclLine <= 1'b0;
  endtask : bit_xfer

  // Eight bits most significant first, then the acknowledge bit
  task automatic xfer_byte(input logic [7:0] txByte, input logic txAck,
                           output logic [7:0] rxByte, output logic rxAck);
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(txByte[i], rxByte[i]);
    end
    bit_xfer(txAck, rxAck);
  endtask : xfer_byte

endmodule : iox_bus_ctrl

// [testbench/iox_expander_tb_top.sv]
// Self-checking bench of the sixteen-bit serial I/O expander
`timescale 1ns/1ps
module iox_expander_tb_top
  import iox_pkg::*;
;
  // ------------------------------------------------------------
  // Stimulus and wires
  // ------------------------------------------------------------
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [2:0] strap;
  logic [7:0] portLoIn;
  logic [7:0] portHiIn;
  logic sclLine;
  logic sdaDrv;
  logic sdaOut;
  logic sdaOe;
  logic intOut;
  logic intOe;
  logic [7:0] portLoOut;
  logic [7:0] portLoOe;
  logic [7:0] portHiOut;
  logic [7:0] portHiOe;
  int errors = 0;
  int checks_done = 0;
  // Open-drain wires with pull-ups
  wire logic sdaLine = sdaDrv & (sdaOe ? sdaOut : 1'b1);
  wire logic intLine = intOe ? intOut : 1'b1;

  // Clock of 8 ns period
  always #4 clk_sys = ~clk_sys;

  iox_expander iox_expander_inst (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .sclIn(sclLine),
    .sdaIn(sdaLine),
    .sdaOut(sdaOut),
    .sdaOe(sdaOe),
    .addrStrap0(strap[0]),
    .addrStrap1(strap[1]),
    .addrStrap2(strap[2]),
    .portLoIn(portLoIn),
    .portLoOut(portLoOut),
    .portLoOe(portLoOe),
    .portHiIn(portHiIn),
    .portHiOut(portHiOut),
    .portHiOe(portHiOe),
    .intOut(intOut),
    .intOe(intOe)
  );

  iox_bus_ctrl iox_bus_ctrl_inst (
    .clk_sys(clk_sys),
    .sdaLine(sdaLine),
    .sclLine(sclLine),
    .sdaDrv(sdaDrv)
  );

  // ------------------------------------------------------------
  // Compare and report
  // ------------------------------------------------------------
  // Byte compare
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check8

  // Single bit compare
  task automatic check1(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check1

  // Verdict and end of run
  task automatic results();
    $display("checks_done=%0d errors=%0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results

  // ------------------------------------------------------------
  // Bus access tasks
  // ------------------------------------------------------------
  // Address byte only, acknowledge compared
  task automatic probe(input logic [2:0] s, input logic expAck);
    logic [7:0] junk;
    logic ack;
    iox_bus_ctrl_inst.start_cond();
    iox_bus_ctrl_inst.xfer_byte({DEV_ADDR_BASE, s, 1'b0}, 1'b1, junk, ack);
    check1(ack, expAck);
    iox_bus_ctrl_inst.stop_cond();
  endtask : probe

  // Command then two data bytes, pointer toggles between them
  task automatic wr_pair(input logic [2:0] ptr, input logic [7:0] d0, input logic [7:0] d1);
    logic [7:0] junk;
    logic ack;
    iox_bus_ctrl_inst.start_cond();
    iox_bus_ctrl_inst.xfer_byte({DEV_ADDR_BASE, strap, 1'b0}, 1'b1, junk, ack);
    check1(ack, 1'b0);
    iox_bus_ctrl_inst.xfer_byte({5'h00, ptr}, 1'b1, junk, ack);
    check1(ack, 1'b0);
    iox_bus_ctrl_inst.xfer_byte(d0, 1'b1, junk, ack);
    check1(ack, 1'b0);
    iox_bus_ctrl_inst.xfer_byte(d1, 1'b1, junk, ack);
    check1(ack, 1'b0);
    iox_bus_ctrl_inst.stop_cond();
  endtask : wr_pair

  // Command, repeated start, two bytes read, last one refused
  task automatic rd_pair(input logic [2:0] ptr, output logic [7:0] d0, output logic [7:0] d1);
    logic [7:0] junk;
    logic ack;
    iox_bus_ctrl_inst.start_cond();
    iox_bus_ctrl_inst.xfer_byte({DEV_ADDR_BASE, strap, 1'b0}, 1'b1, junk, ack);
    check1(ack, 1'b0);
    iox_bus_ctrl_inst.xfer_byte({5'h00, ptr}, 1'b1, junk, ack);
    check1(ack, 1'b0);
    iox_bus_ctrl_inst.start_cond();
    iox_bus_ctrl_inst.xfer_byte({DEV_ADDR_BASE, strap, 1'b1}, 1'b1, junk, ack);
    check1(ack, 1'b0);
    iox_bus_ctrl_inst.xfer_byte(8'hFF, 1'b0, d0, ack);
    iox_bus_ctrl_inst.xfer_byte(8'hFF, 1'b1, d1, ack);
    iox_bus_ctrl_inst.stop_cond();
  endtask : rd_pair

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  // Main sequence of bus calls with expected values
  initial begin
    logic [7:0] rdA;
    logic [7:0] rdB;
    logic [7:0] expTab [8];
    expTab = '{8'h00, 8'h00, 8'h5A, 8'hC3, 8'hFF, 8'h00, 8'h0F, 8'hF0};
    strap <= 3'h5;
    portLoIn <= 8'hA5;
    portHiIn <= 8'h3C;
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (12) @(posedge clk_sys);
    check8(portLoOe, 8'h00);
    check8(portHiOe, 8'h00);
    check8(portLoOut, RST_OUT);
    check8(portHiOut, RST_OUT);
    check1(intOe, 1'b0);
    check1(sdaOe, 1'b0);
    // Every strap setting: own address acked, neighbour refused
    for (int s = 0; s < 8; s++) begin
      strap <= 3'(s);
      iox_bus_ctrl_inst.tick(10);
      probe(3'(s) ^ 3'h1, 1'b1);
      probe(3'(s), 1'b0);
    end
    for (int k = 1; k < 4; k++) begin
      wr_pair(3'(2 * k), expTab[2 * k], expTab[2 * k + 1]);
    end
    check8(portLoOut, 8'h5A);
    check8(portHiOut, 8'hC3);
    check8(portLoOe, 8'hF0);
    check8(portHiOe, 8'h0F);
    for (int k = 1; k < 4; k++) begin
      rd_pair(3'(2 * k), rdA, rdB);
      check8(rdA, expTab[2 * k]);
      check8(rdB, expTab[2 * k + 1]);
    end
    check8(portLoOut, 8'h5A);
    // Input registers ignore writes and report pins through polarity
    wr_pair(REG_IN_LO, 8'h96, 8'h69);
    rd_pair(REG_IN_LO, rdA, rdB);
    check8(rdA, 8'h5A);
    check8(rdB, 8'h3C);
    // Interrupt raised by a change, cleared by return and by a read
    portLoIn <= 8'hA4;
    iox_bus_ctrl_inst.tick(10);
    check1(intOe, 1'b1);
    check1(intLine, 1'b0);
    portLoIn <= 8'hA5;
    iox_bus_ctrl_inst.tick(10);
    check1(intOe, 1'b0);
    check1(intLine, 1'b1);
    portHiIn <= 8'h3D;
    iox_bus_ctrl_inst.tick(10);
    check1(intOe, 1'b1);
    rd_pair(REG_IN_HI, rdA, rdB);
    check8(rdA, 8'h3D);
    check8(rdB, 8'h5A);
    check1(intOe, 1'b0);
    // Second reset in mid-run returns defaults
    nrst <= 1'b0;
    iox_bus_ctrl_inst.tick(2);
    check8(portLoOe, 8'h00);
    check8(portHiOut, RST_OUT);
    nrst <= 1'b1;
    iox_bus_ctrl_inst.tick(12);
    rd_pair(REG_CFG_LO, rdA, rdB);
    check8(rdA, RST_CFG);
    check8(rdB, RST_CFG);
    results();
  end

  // Watchdog against a hung transfer
  initial begin
    repeat (40000) @(posedge clk_sys);
    errors++;
    results();
  end

endmodule : iox_expander_tb_top
